// ---- hdl/pmw_pkg.sv ----
// Shared constants and types for the power-mode and wake-up controller
package pmw_pkg;
    localparam int CLK_MHZ = 50;
    // Stabilisation counts in oscillator cycles
    localparam logic [10:0] XTAL_SETTLE_CYC = 11'h400;
    localparam logic [10:0] RC_HIGH_SETTLE_CYC = 11'h00f;
    localparam logic [10:0] SHORT_WAKE_CYC = 11'h001;
    localparam logic [10:0] CNT_RESET = 11'h000;
    // Divider selections that pick the low-speed source
    localparam logic [2:0] DIV_SUB_A = 3'h0;
    localparam logic [2:0] DIV_SUB_B = 3'h1;
    // System oscillator kinds
    typedef enum logic [1:0] {OSC_XTAL_HIGH, OSC_RC_HIGH, OSC_RC_LOW, OSC_XTAL_LOW} pmw_osc_type;
    typedef enum {ST_FAST_RUN, ST_SLOW_RUN, ST_DEEP_SLEEP, ST_LIGHT_SLEEP, ST_IDLE_OFF, ST_IDLE_ON,
                  ST_WAKE_WAIT, ST_WAKE_TEMP} pmw_mode_type;
endpackage

// ---- hdl/pmw_edge_count.sv ----
// Oscillator edge counter: synchronises a tick and counts it to a target
`timescale 1ns/10ps
`default_nettype none
module pmw_edge_count
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic clear,
    input wire logic osc_tick,
    input wire logic [10:0] target,
    output logic done
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic [10:0] cnt;
        logic done;
    } pmw_cnt_type;
    pmw_cnt_type r;
    pmw_cnt_type next_r;

    always_comb
    begin
        next_r = r;
        next_r.s1 = osc_tick;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        if (clear)
        begin
            next_r.cnt = pmw_pkg::CNT_RESET;
            next_r.done = 1'b0;
        end
        else if (r.s2 && !r.s3 && !r.done)
        begin
            next_r.cnt = r.cnt + 11'h001;
            if (r.cnt + 11'h001 >= target)
                next_r.done = 1'b1;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            r <= '0;
        else
            r <= next_r;
    end
    assign done = r.done;
endmodule
`default_nettype wire

// ---- hdl/pmw_ctrl.sv ----
// Power-mode, clock-switching and wake-up controller
`timescale 1ns/10ps
`default_nettype none
module pmw_ctrl
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic STOP_INSTRUCTION,
    input wire logic WAKE_EVENT,
    input wire logic IDLE_ENABLE,
    input wire logic IDLE_CLOCK_KEEP,
    input wire logic FAST_WAKE_ENABLE,
    input wire logic SYSTEM_CLOCK_SELECT,
    input wire logic [2:0] CLOCK_DIVIDER_SELECT,
    input wire logic [1:0] SYSTEM_OSC_KIND,
    input wire logic WATCHDOG_ON,
    input wire logic VOLTAGE_DETECTOR_ON,
    input wire logic HIGH_OSC_TICK,
    input wire logic LOW_OSC_TICK,
    input wire logic LOW_OSC_STABLE,
    input wire logic STATUS_CLEAR,
    output logic HIGH_OSC_ENABLE,
    output logic SUB_CLOCK_ENABLE,
    output logic SYSTEM_CLOCK_RUN,
    output logic SYSTEM_ON_SUB_CLOCK,
    output logic CPU_HALT,
    output logic STATE_HOLD,
    output logic HIGH_OSC_READY_FLAG,
    output logic LOW_OSC_READY_FLAG,
    output logic POWER_DOWN_FLAG,
    output logic TIMEOUT_FLAG,
    output logic WATCHDOG_CLEAR,
    output logic WATCHDOG_RUN
);
    typedef struct packed {
        logic [2:0] sync_in;
        logic [2:0] sync_out;
        logic wake_s1;
        logic wake_s2;
        logic stop_s1;
        logic stop_s2;
        logic stop_s3;
        logic lsta_s1;
        logic lsta_s2;
        pmw_pkg::pmw_mode_type mode;
        logic fast_wake;
        logic short_wake;
        logic hi_osc_en;
        logic sub_en;
        logic sys_run;
        logic on_sub;
        logic halt;
        logic hold;
        logic hi_ready;
        logic lo_ready;
        logic power_down_flag;
        logic tof;
        logic wdt_clr;
        logic wdt_run;
    } pmw_ctrl_type;
    pmw_ctrl_type r;
    pmw_ctrl_type next_r;
    logic cnt_clear;
    logic cnt_done;
    logic [10:0] cnt_target;
    logic sel_tick;
    logic stop_pulse;
    logic slow_req;
    logic sub_needed;

    assign stop_pulse = r.stop_s2 && !r.stop_s3;
    // Slow run: select low and the divider picks the sub clock
    assign slow_req = !SYSTEM_CLOCK_SELECT &&
        (CLOCK_DIVIDER_SELECT == pmw_pkg::DIV_SUB_A || CLOCK_DIVIDER_SELECT == pmw_pkg::DIV_SUB_B);
    assign sub_needed = WATCHDOG_ON || VOLTAGE_DETECTOR_ON;
    // Crystals settle on 1024 edges, high RC on 15, low RC one edge after sync
    // The idle state is gone once counting starts, so a latched flag marks the short wake
    assign cnt_target = (r.short_wake || SYSTEM_OSC_KIND == pmw_pkg::OSC_RC_LOW) ? pmw_pkg::SHORT_WAKE_CYC :
        (SYSTEM_OSC_KIND == pmw_pkg::OSC_RC_HIGH) ? pmw_pkg::RC_HIGH_SETTLE_CYC : pmw_pkg::XTAL_SETTLE_CYC;
    assign sel_tick = (SYSTEM_OSC_KIND == pmw_pkg::OSC_RC_LOW || SYSTEM_OSC_KIND == pmw_pkg::OSC_XTAL_LOW)
        ? LOW_OSC_TICK : HIGH_OSC_TICK;
    assign cnt_clear = !(r.mode == pmw_pkg::ST_WAKE_WAIT || r.mode == pmw_pkg::ST_WAKE_TEMP);

    pmw_edge_count u_settle
    (
        .CLK(CLK),
        .RSTN(RSTN),
        .clear(cnt_clear),
        .osc_tick(sel_tick),
        .target(cnt_target),
        .done(cnt_done)
    );

    always_comb
    begin
        next_r = r;
        next_r.wake_s1 = WAKE_EVENT;
        next_r.wake_s2 = r.wake_s1;
        next_r.stop_s1 = STOP_INSTRUCTION;
        next_r.stop_s2 = r.stop_s1;
        next_r.stop_s3 = r.stop_s2;
        next_r.lsta_s1 = LOW_OSC_STABLE;
        next_r.lsta_s2 = r.lsta_s1;
        next_r.wdt_clr = 1'b0;
        next_r.lo_ready = r.lsta_s2 && r.sub_en;
        if (STATUS_CLEAR)
        begin
            next_r.power_down_flag = 1'b0;
        end
        unique case (r.mode)
            pmw_pkg::ST_FAST_RUN, pmw_pkg::ST_SLOW_RUN:
            begin
                next_r.halt = 1'b0;
                next_r.hold = 1'b0;
                next_r.sys_run = 1'b1;
                next_r.sub_en = 1'b1;
                next_r.short_wake = 1'b0;
                if (slow_req && r.lo_ready)
                begin
                    next_r.mode = pmw_pkg::ST_SLOW_RUN;
                    next_r.on_sub = 1'b1;
                    next_r.hi_osc_en = 1'b0;
                    next_r.hi_ready = 1'b0;
                end
                else if (!slow_req)
                begin
                    next_r.mode = pmw_pkg::ST_FAST_RUN;
                    next_r.hi_osc_en = 1'b1;
                    next_r.on_sub = 1'b0;
                    if (!r.hi_ready)
                        next_r.mode = pmw_pkg::ST_WAKE_WAIT;
                end
                if (stop_pulse)
                begin
                    next_r.halt = 1'b1;
                    next_r.hold = 1'b1;
                    next_r.power_down_flag = 1'b1;
                    next_r.tof = 1'b0;
                    next_r.wdt_clr = 1'b1;
                    if (IDLE_ENABLE)
                    begin
                        next_r.mode = IDLE_CLOCK_KEEP ? pmw_pkg::ST_IDLE_ON : pmw_pkg::ST_IDLE_OFF;
                        next_r.sys_run = IDLE_CLOCK_KEEP;
                        next_r.wdt_run = 1'b1;
                    end
                    else if (!sub_needed)
                    begin
                        next_r.mode = pmw_pkg::ST_DEEP_SLEEP;
                        next_r.sys_run = 1'b0;
                        next_r.sub_en = 1'b0;
                        next_r.hi_osc_en = 1'b0;
                        next_r.wdt_run = 1'b0;
                    end
                    else
                    begin
                        next_r.mode = pmw_pkg::ST_LIGHT_SLEEP;
                        next_r.sys_run = 1'b0;
                        next_r.wdt_run = 1'b1;
                    end
                    if (!IDLE_CLOCK_KEEP || !IDLE_ENABLE)
                        next_r.hi_ready = 1'b0;
                end
            end
            pmw_pkg::ST_DEEP_SLEEP, pmw_pkg::ST_LIGHT_SLEEP, pmw_pkg::ST_IDLE_OFF, pmw_pkg::ST_IDLE_ON:
            begin
                if (r.wake_s2)
                begin
                    next_r.sub_en = 1'b1;
                    next_r.hi_osc_en = !r.on_sub;
                    next_r.wdt_run = sub_needed;
                    // temp clock not from deep sleep
                    next_r.fast_wake = FAST_WAKE_ENABLE && !r.on_sub &&
                        SYSTEM_OSC_KIND == pmw_pkg::OSC_XTAL_HIGH &&
                        (r.mode == pmw_pkg::ST_LIGHT_SLEEP || r.mode == pmw_pkg::ST_IDLE_OFF);
                    next_r.short_wake = (r.mode == pmw_pkg::ST_IDLE_ON);
                    next_r.mode = r.on_sub ? pmw_pkg::ST_SLOW_RUN :
                        (FAST_WAKE_ENABLE && SYSTEM_OSC_KIND == pmw_pkg::OSC_XTAL_HIGH &&
                        (r.mode == pmw_pkg::ST_LIGHT_SLEEP || r.mode == pmw_pkg::ST_IDLE_OFF)) ?
                        pmw_pkg::ST_WAKE_TEMP : pmw_pkg::ST_WAKE_WAIT;
                    if (r.on_sub)
                    begin
                        next_r.sys_run = 1'b1;
                        next_r.halt = 1'b0;
                        next_r.hold = 1'b0;
                    end
                end
            end
            pmw_pkg::ST_WAKE_TEMP:
            begin
                next_r.sys_run = 1'b1;
                next_r.on_sub = 1'b1;
                next_r.halt = 1'b0;
                next_r.hold = 1'b0;
                if (cnt_done)
                begin
                    next_r.hi_ready = 1'b1;
                    next_r.on_sub = 1'b0;
                    next_r.fast_wake = 1'b0;
                    next_r.mode = pmw_pkg::ST_FAST_RUN;
                end
            end
            pmw_pkg::ST_WAKE_WAIT:
            begin
                next_r.hi_osc_en = 1'b1;
                if (cnt_done)
                begin
                    next_r.hi_ready = 1'b1;
                    next_r.sys_run = 1'b1;
                    next_r.on_sub = 1'b0;
                    next_r.halt = 1'b0;
                    next_r.hold = 1'b0;
                    next_r.mode = pmw_pkg::ST_FAST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            r <= '0;
            r.mode <= pmw_pkg::ST_WAKE_WAIT;
            r.hi_osc_en <= 1'b1;
            r.sub_en <= 1'b1;
        end
        else
            r <= next_r;
    end

    assign HIGH_OSC_ENABLE = r.hi_osc_en;
    assign SUB_CLOCK_ENABLE = r.sub_en;
    assign SYSTEM_CLOCK_RUN = r.sys_run;
    assign SYSTEM_ON_SUB_CLOCK = r.on_sub;
    assign CPU_HALT = r.halt;
    assign STATE_HOLD = r.hold;
    assign HIGH_OSC_READY_FLAG = r.hi_ready;
    assign LOW_OSC_READY_FLAG = r.lo_ready;
    assign POWER_DOWN_FLAG = r.power_down_flag;
    assign TIMEOUT_FLAG = r.tof;
    assign WATCHDOG_CLEAR = r.wdt_clr;
    assign WATCHDOG_RUN = r.wdt_run;

    a_deep_stops_clocks: assert property (@(posedge CLK) disable iff (!RSTN)
        r.mode == pmw_pkg::ST_DEEP_SLEEP |-> !r.sub_en && !r.sys_run)
        else $error("deep sleep with a clock running");
    a_light_keeps_sub: assert property (@(posedge CLK) disable iff (!RSTN)
        r.mode == pmw_pkg::ST_LIGHT_SLEEP |-> r.sub_en && r.wdt_run && !r.sys_run)
        else $error("light sleep lost sub clock");
    a_sleep_flags: assert property (@(posedge CLK) disable iff (!RSTN)
        $rose(r.halt) |-> r.power_down_flag && !r.tof && r.wdt_clr)
        else $error("sleep entry flags wrong");
    a_slow_stops_high: assert property (@(posedge CLK) disable iff (!RSTN)
        r.mode == pmw_pkg::ST_SLOW_RUN |-> !r.hi_osc_en)
        else $error("high clock running in slow run");
    a_temp_not_deep: assert property (@(posedge CLK) disable iff (!RSTN)
        $past(r.mode) == pmw_pkg::ST_DEEP_SLEEP |-> r.mode != pmw_pkg::ST_WAKE_TEMP)
        else $error("temp clock from deep sleep");
    a_idle_keep: assert property (@(posedge CLK) disable iff (!RSTN)
        r.mode == pmw_pkg::ST_IDLE_ON |-> r.sys_run && r.halt)
        else $error("idle clock-on lost system clock");
    a_ready_then_run: assert property (@(posedge CLK) disable iff (!RSTN)
        $rose(r.hi_ready) |-> r.mode == pmw_pkg::ST_FAST_RUN && !r.on_sub)
        else $error("ready without switching to high clock");
    a_hold_in_sleep: assert property (@(posedge CLK) disable iff (!RSTN)
        r.mode == pmw_pkg::ST_LIGHT_SLEEP |-> r.hold && r.halt)
        else $error("state not held in sleep");
endmodule
`default_nettype wire

// ---- tb/pmw_osc_model.sv ----
// Oscillator model: high and low square waves that run only while enabled
`timescale 1ns/10ps
`default_nettype none
module pmw_osc_model
#(
    parameter int HIGH_HALF = 2,
    parameter int LOW_HALF = 8,
    parameter int SETTLE_TICKS = 4
)
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic HIGH_OSC_ENABLE,
    input wire logic SUB_CLOCK_ENABLE,
    output logic HIGH_OSC_TICK,
    output logic LOW_OSC_TICK,
    output logic LOW_OSC_STABLE
);
    int high_cnt = 0;
    int low_cnt = 0;
    int low_edges = 0;

    initial
    begin
        HIGH_OSC_TICK = 1'b0;
        LOW_OSC_TICK = 1'b0;
        LOW_OSC_STABLE = 1'b0;
    end

    // A stopped oscillator rests low, so no stray edge reaches the counters
    always @(posedge CLK)
    begin
        #1;
        if (!RSTN || !HIGH_OSC_ENABLE)
        begin
            high_cnt = 0;
            HIGH_OSC_TICK = 1'b0;
        end
        else if (++high_cnt >= HIGH_HALF)
        begin
            high_cnt = 0;
            HIGH_OSC_TICK = ~HIGH_OSC_TICK;
        end
        if (!RSTN || !SUB_CLOCK_ENABLE)
        begin
            low_cnt = 0;
            low_edges = 0;
            LOW_OSC_TICK = 1'b0;
        end
        else if (++low_cnt >= LOW_HALF)
        begin
            low_cnt = 0;
            LOW_OSC_TICK = ~LOW_OSC_TICK;
            if (LOW_OSC_TICK)
                low_edges++;
        end
        LOW_OSC_STABLE = (low_edges >= SETTLE_TICKS);
    end
endmodule
`default_nettype wire

// ---- tb/pmw_ctrl_test.sv ----
// Self-checking testbench for the power-mode and wake-up controller
`timescale 1ns/10ps
`default_nettype none
module pmw_ctrl_test;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic stop = 1'b0;
    logic wake = 1'b0;
    logic idle_en = 1'b0;
    logic keep = 1'b0;
    logic fast = 1'b0;
    logic sel = 1'b1;
    logic [2:0] div = 3'h7;
    logic [1:0] kind = 2'h0;
    logic wdt = 1'b0;
    logic voltage_detector = 1'b0;
    logic st_clr = 1'b0;
    logic h_tick, l_tick, l_stable;
    logic h_en, s_en, run, on_sub, halt, hold, h_rdy, l_rdy, power_down_flag, tof, w_clr, w_run;
    int miscompares = 0;
    int compares = 0;
    int clears = 0;
    int n;
    bit sub_seen;

    always #10 clk = ~clk;

    always @(posedge clk)
        if (w_clr === 1'b1)
            clears++;

    pmw_ctrl DUT (.CLK(clk), .RSTN(rstn), .STOP_INSTRUCTION(stop), .WAKE_EVENT(wake), .IDLE_ENABLE(idle_en),
        .IDLE_CLOCK_KEEP(keep), .FAST_WAKE_ENABLE(fast), .SYSTEM_CLOCK_SELECT(sel), .CLOCK_DIVIDER_SELECT(div),
        .SYSTEM_OSC_KIND(kind), .WATCHDOG_ON(wdt), .VOLTAGE_DETECTOR_ON(voltage_detector), .HIGH_OSC_TICK(h_tick),
        .LOW_OSC_TICK(l_tick), .LOW_OSC_STABLE(l_stable), .STATUS_CLEAR(st_clr), .HIGH_OSC_ENABLE(h_en),
        .SUB_CLOCK_ENABLE(s_en), .SYSTEM_CLOCK_RUN(run), .SYSTEM_ON_SUB_CLOCK(on_sub), .CPU_HALT(halt),
        .STATE_HOLD(hold), .HIGH_OSC_READY_FLAG(h_rdy), .LOW_OSC_READY_FLAG(l_rdy), .POWER_DOWN_FLAG(power_down_flag),
        .TIMEOUT_FLAG(tof), .WATCHDOG_CLEAR(w_clr), .WATCHDOG_RUN(w_run));

    pmw_osc_model osc (.CLK(clk), .RSTN(rstn), .HIGH_OSC_ENABLE(h_en), .SUB_CLOCK_ENABLE(s_en),
        .HIGH_OSC_TICK(h_tick), .LOW_OSC_TICK(l_tick), .LOW_OSC_STABLE(l_stable));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // Waits, bounded, for: 0 ready, 1 halt released, 2 on sub clock, 3 back on high clock
    task automatic wait_on(input int which, output int cyc);
        cyc = 0;
        sub_seen = 0;
        while (cyc < 6000 && !((which == 0 && h_rdy === 1'b1) || (which == 1 && halt === 1'b0) ||
               (which == 2 && on_sub === 1'b1) || (which == 3 && on_sub === 1'b0 && h_rdy === 1'b1)))
        begin
            step(1);
            cyc++;
            sub_seen |= (on_sub === 1'b1);
        end
    endtask

    // Halt, check the common entry effects, then wake and measure the release
    task automatic halt_wake(input logic exp_run, input logic exp_sub, output int cyc);
        int c0;
        c0 = clears;
        stop = 1'b1;
        step(5);
        stop = 1'b0;
        check("halt", halt, 1'b1);
        check("hold", hold, 1'b1);
        check("pdf", power_down_flag, 1'b1);
        check("timeout", tof, 1'b0);
        check("wdt clear", clears - c0, 16'h1);
        check("sysrun", run, exp_run);
        check("subclk", s_en, exp_sub);
        check("wdt run", w_run, exp_sub);
        wake = 1'b1;
        wait_on(1, cyc);
        wake = 1'b0;
    endtask

    task automatic t_deep();
        fast = 1'b1;
        halt_wake(1'b0, 1'b0, n);
        check("deep wake slow", n >= 4088 && n <= 4200, 1'b1);
        check("no temp clock", sub_seen, 1'b0);
        check("ready", h_rdy, 1'b1);
        st_clr = 1'b1;
        step(3);
        st_clr = 1'b0;
        check("pdf cleared", power_down_flag, 1'b0);
        $display("deep sleep test done");
    endtask

    task automatic t_light();
        wdt = 1'b1;
        halt_wake(1'b0, 1'b1, n);
        check("fast release", n <= 60, 1'b1);
        check("on sub", sub_seen, 1'b1);
        wait_on(3, n);
        check("switch back", n >= 4000 && n <= 4200, 1'b1);
        fast = 1'b0;
        $display("light sleep test done");
    endtask

    task automatic t_idle();
        idle_en = 1'b1;
        keep = 1'b1;
        halt_wake(1'b1, 1'b1, n);
        check("idle on wake", n <= 20, 1'b1);
        keep = 1'b0;
        halt_wake(1'b0, 1'b1, n);
        check("idle off wake", n >= 4088 && n <= 4200, 1'b1);
        idle_en = 1'b0;
        $display("idle test done");
    endtask

    task automatic t_rc();
        kind = 2'h1;
        halt_wake(1'b0, 1'b1, n);
        check("rc high wake", n >= 52 && n <= 92, 1'b1);
        check("no temp clock", sub_seen, 1'b0);
        kind = 2'h2;
        halt_wake(1'b0, 1'b1, n);
        check("rc low wake", n <= 60, 1'b1);
        kind = 2'h0;
        wait_on(0, n);
        $display("rc test done");
    endtask

    task automatic t_slow();
        for (int i = 0; i < 2; i++)
        begin
            sel = 1'b0;
            div = i[2:0];
            wait_on(2, n);
            check("slow entry", n < 400, 1'b1);
            check("low ready", l_rdy, 1'b1);
            step(3);
            check("high stopped", h_en, 1'b0);
            div = i ? 3'h7 : 3'h2;
            sel = i[0];
            wait_on(3, n);
            check("fast back", n >= 4000 && n <= 4200, 1'b1);
            check("high on", h_en, 1'b1);
        end
        $display("slow run test done");
    endtask

    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        $display("watchdog expired");
        complete_run();
    end

    initial
    begin
        step(20);
        rstn = 1'b1;
        wait_on(0, n);
        check("reset ready", h_rdy, 1'b1);
        check("reset run", run, 1'b1);
        t_deep();
        t_light();
        t_idle();
        t_rc();
        t_slow();
        complete_run();
    end
endmodule
`default_nettype wire
